//--- hw/ulpi_hs_pkg.sv
// shared constants for the ulpi bus handshake block
package ulpi_hs_pkg;
  localparam int unsigned DATA_W        = 8;          // parallel bus width
  localparam int unsigned SYS_CLK_MHZ   = 250;        // block clock rate
  localparam int unsigned IFC_CLK_MHZ   = 60;         // link interface clock rate, unused; divider gives 31.25
  localparam int unsigned IFC_DIV       = 4;          // sys cycles per ifc half period
  localparam int unsigned DIV_W         = 3;          // divider counter width
  localparam logic [7:0]  RXCMD_IDLE    = 8'h00;      // rxcmd reset value
  localparam logic [7:0]  TXCMD_NONE    = 8'h00;      // idle bus value from link
  localparam logic [1:0]  MODE_SYNC     = 2'h0;       // synchronous mode code
  localparam logic [1:0]  MODE_LOWPWR   = 2'h1;       // low-power mode code
  localparam logic [1:0]  MODE_SERIAL   = 2'h2;       // serial mode code
  localparam logic [1:0]  MODE_UART     = 2'h3;       // uart mode code
endpackage

//--- hw/ulpi_bus_handshake.sv
// device-side dir/nxt/stp handshake of a ulpi parallel bus
//
// What this block and its link do
// [RULE1] dir low by default in sync mode
// [RULE2] in sync mode, dir high only with bytes for link
// [RULE3] dir and nxt high means usb data
// [RULE4] dir high nxt low: rxcmd or readback
// [RULE5] each dir change gives one turnaround cycle
// [RULE6] dir held high in non-sync modes
// [RULE7] link pulses stp after last byte
// [RULE8] stp from link forces dir low
// [RULE9] held stp wakes device to sync
// [RULE10] dir low: nxt requests next tx byte
// [RULE11] dir high: nxt marks valid usb byte
// [RULE12] nxt unused outside sync mode
// [RULE13] link idles bus low, txcmd nonzero
// [RULE14] link ignores bus one cycle after dir
// [RULE15] device supplies interface clock, sync signals
// [RULE16] link releases bus while dir high
`timescale 1ns/1ps
module ulpi_bus_handshake
  import ulpi_hs_pkg::*;
(
  input  wire logic              clk_sys_i,     // block clock
  input  wire logic              rst_i,         // sync reset, active high
  output logic                   ifc_clk_o,     // interface clock to link
  input  wire logic              stp_i,         // stop from link (async pin)
  input  wire logic [DATA_W-1:0] data_i,        // bus level seen at pins
  output logic [DATA_W-1:0]      data_o,        // bus value driven by device
  output logic [DATA_W-1:0]      data_oe_o,     // high while device drives bus
  output logic                   dir_o,         // bus direction, high = to link
  output logic                   nxt_o,         // throttle / data valid
  input  wire logic [1:0]        mode_i,        // operating mode request
  input  wire logic              rx_valid_i,    // usb rx byte available
  input  wire logic [DATA_W-1:0] rx_data_i,     // usb rx byte
  input  wire logic              rxcmd_req_i,   // status change pending
  input  wire logic [DATA_W-1:0] rxcmd_i,       // status byte
  input  wire logic              rd_valid_i,    // register read data ready
  input  wire logic [DATA_W-1:0] rd_data_i,     // register read data
  output logic                   rx_taken_o,    // rx byte consumed (pulse)
  output logic                   rxcmd_taken_o, // rxcmd consumed (pulse)
  output logic                   rd_taken_o,    // read data consumed (pulse)
  input  wire logic              tx_ready_i,    // core can accept tx byte
  output logic                   tx_valid_o,    // tx byte captured (pulse)
  output logic [DATA_W-1:0]      tx_data_o,     // captured tx byte
  output logic                   tx_last_o,     // stp ended transfer (pulse)
  output logic                   wake_o         // wake request seen (pulse)
);

  // bus states
  typedef enum logic [2:0] {
    ST_LISTEN,   // dir low, waiting for txcmd
    ST_TX,       // dir low, taking bytes
    ST_TURN_UP,  // turnaround toward link
    ST_DRIVE,    // dir high, driving bytes
    ST_TURN_DN,  // turnaround toward device
    ST_PARKED    // non-sync mode, dir held high
  } bus_state_t;

  bus_state_t        state_q;     // current bus state
  logic [DIV_W-1:0]  div_q;       // interface clock divider
  logic              tick;        // one interface cycle enable
  logic              stp_m_q;     // stp sync stage 1
  logic              stp_s_q;     // stp sync stage 2
  logic [DATA_W-1:0] din_m_q;     // data sync stage 1
  logic [DATA_W-1:0] din_s_q;     // data sync stage 2
  logic              nxt_q;       // registered nxt
  logic [DATA_W-1:0] dout_q;      // registered bus output
  logic              sync_mode;   // synchronous mode selected
  logic              have_data;   // something to deliver
  logic              rx_take;     // rx byte goes out this cycle
  logic              rd_take;     // read data goes out this cycle
  logic              cmd_take;    // rxcmd goes out this cycle

  // divider: interface clock and a one-cycle enable per rising edge
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      div_q     <= '0;
      ifc_clk_o <= 1'b0;
    end else if (div_q == DIV_W'(IFC_DIV - 1)) begin
      div_q     <= '0;
      ifc_clk_o <= ~ifc_clk_o;  // see [RULE15]
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end
  // bus updates at interface rising edge; link samples it half a period later, at the falling edge
  assign tick = (div_q == DIV_W'(IFC_DIV - 1)) && !ifc_clk_o;

  // two-flop synchronisers for pin inputs
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      stp_m_q <= 1'b0;
      stp_s_q <= 1'b0;
      din_m_q <= '0;
      din_s_q <= '0;
    end else begin
      stp_m_q <= stp_i;
      stp_s_q <= stp_m_q;
      din_m_q <= data_i;
      din_s_q <= din_m_q;
    end
  end

  assign sync_mode = (mode_i == MODE_SYNC);
  assign have_data = rx_valid_i || rxcmd_req_i || rd_valid_i;

  // in drive state: usb data beats read data beats status
  assign rx_take  = tick && (state_q == ST_DRIVE) && !stp_s_q && rx_valid_i;
  assign rd_take  = tick && (state_q == ST_DRIVE) && !stp_s_q && !rx_valid_i && rd_valid_i;
  assign cmd_take = tick && (state_q == ST_DRIVE) && !stp_s_q && !rx_valid_i && !rd_valid_i
                    && rxcmd_req_i;

  // bus state machine
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= ST_LISTEN;  // see [RULE1]
    end else if (tick) begin
      unique case (state_q)
        ST_LISTEN: begin
          if (!sync_mode) begin
            state_q <= ST_TURN_UP;
          end else if (din_s_q != TXCMD_NONE) begin
            state_q <= ST_TX;  // nonzero byte is a txcmd
          end else if (have_data) begin
            state_q <= ST_TURN_UP;  // see [RULE2]
          end
        end
        ST_TX: begin
          if (stp_s_q) begin
            state_q <= ST_LISTEN;  // see [RULE7]
          end
        end
        ST_TURN_UP: begin
          state_q <= sync_mode ? ST_DRIVE : ST_PARKED;  // see [RULE5]
        end
        ST_DRIVE: begin
          if (!sync_mode) begin
            state_q <= ST_PARKED;
          end else if (stp_s_q || !have_data) begin
            state_q <= ST_TURN_DN;  // see [RULE8]
          end
        end
        ST_TURN_DN: begin
          state_q <= ST_LISTEN;  // see [RULE5]
        end
        ST_PARKED: begin
          if (stp_s_q) begin
            state_q <= ST_TURN_DN;  // see [RULE9]
          end
        end
      endcase
    end
  end

  // dir from state: high in turn-up, drive and parked
  always_comb begin
    dir_o = (state_q == ST_TURN_UP) || (state_q == ST_DRIVE)
            || (state_q == ST_PARKED);  // see [RULE6]
  end

  // nxt and outgoing byte, one interface cycle each
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      nxt_q  <= 1'b0;
      dout_q <= RXCMD_IDLE;
    end else if (tick) begin
      if (rx_take) begin
        nxt_q  <= 1'b1;  // see [RULE11]
        dout_q <= rx_data_i;  // see [RULE3]
      end else if (rd_take) begin
        nxt_q  <= 1'b0;
        dout_q <= rd_data_i;  // see [RULE4]
      end else if (cmd_take) begin
        nxt_q  <= 1'b0;
        dout_q <= rxcmd_i;  // see [RULE4]
      end else if (state_q == ST_TX || (state_q == ST_LISTEN && din_s_q != TXCMD_NONE)) begin
        nxt_q <= tx_ready_i && !stp_s_q;  // see [RULE10]
      end else begin
        nxt_q <= 1'b0;  // held low where it has no meaning, see [RULE12]
      end
    end
  end

  // bus drive only in drive state; turnaround leaves bus released
  assign nxt_o     = nxt_q;
  assign data_o    = dout_q;
  assign data_oe_o = {DATA_W{state_q == ST_DRIVE}};

  // core-side pulses
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_valid_o    <= 1'b0;
      tx_data_o     <= '0;
      tx_last_o     <= 1'b0;
      wake_o        <= 1'b0;
      rx_taken_o    <= 1'b0;
      rd_taken_o    <= 1'b0;
      rxcmd_taken_o <= 1'b0;
    end else begin
      // byte after an nxt cycle belongs to the transfer
      tx_valid_o    <= tick && state_q == ST_TX && nxt_q && !stp_s_q;  // see [RULE10]
      tx_last_o     <= tick && state_q == ST_TX && stp_s_q;
      wake_o        <= tick && state_q == ST_PARKED && stp_s_q;
      rx_taken_o    <= rx_take;
      rd_taken_o    <= rd_take;
      rxcmd_taken_o <= cmd_take;
      if (tick && state_q == ST_TX && nxt_q) begin
        tx_data_o <= din_s_q;
      end
    end
  end

  // dir never jumps straight between drive and listen
  no_skip_turn_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == ST_DRIVE && tick && sync_mode && (stp_s_q || !have_data))
    |=> state_q == ST_TURN_DN) else $error("no turnaround after drive");  // see [RULE5]
  // bus released during turnaround
  turn_release_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == ST_TURN_UP || state_q == ST_TURN_DN) |-> data_oe_o == '0)
    else $error("bus driven in turnaround");  // see [RULE5]
  // dir low means device not driving
  dir_low_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !dir_o |-> data_oe_o == '0) else $error("drive with dir low");  // see [RULE1]
  // parked keeps dir high until stp
  parked_dir_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == ST_PARKED && !stp_s_q) |=> dir_o) else $error("dir dropped parked");  // see [RULE6]
  // stp while parked leads to turn-down on the next cycle, with dir low
  wake_path_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == ST_PARKED && tick && stp_s_q) |=> state_q == ST_TURN_DN ##[1:8] !dir_o)
    else $error("wake did not return to sync");  // see [RULE9]
  // usb byte goes out with nxt
  rx_nxt_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rx_take |=> nxt_o && data_o == $past(rx_data_i)) else $error("rx byte without nxt");  // see [RULE11]
  // status and readback go out with nxt low
  cmd_nxt_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rd_take || cmd_take) |=> !nxt_o) else $error("rxcmd with nxt high");  // see [RULE4]
  // dir raised only with data or non-sync mode
  dir_cause_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == ST_LISTEN && $rose(dir_o) == 1'b0 && tick && sync_mode && !have_data
     && din_s_q == TXCMD_NONE) |=> !dir_o) else $error("dir raised without data");  // see [RULE2]
  // stp in drive drops dir at turn-down
  stp_drop_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == ST_DRIVE && tick && stp_s_q && sync_mode) |=> ##[1:8] !dir_o)
    else $error("stp ignored");  // see [RULE8]
  // nxt never high once parked for three cycles
  nxt_mode_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == ST_PARKED && $past(state_q) == ST_PARKED && $past(state_q, 2) == ST_PARKED)
    |-> !nxt_o) else $error("nxt in non-sync mode");  // see [RULE12]
  // stp ends transmit on next tick
  tx_end_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_q == ST_TX && tick && stp_s_q) |=> state_q == ST_LISTEN && tx_last_o)
    else $error("stp did not end tx");  // see [RULE7]

  // bus outputs move only on interface edges
  // link samples half a period later, so mid-cycle changes would be seen torn
  nxt_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // see [RULE15]
    !tick |=> $stable(nxt_o))
    else $error("nxt changed between ticks");

  // dir steps with the state register only
  // a stray dir glitch would start a false turnaround at the link
  dir_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // see [RULE5]
    !tick |=> $stable(dir_o))
    else $error("dir changed between ticks");

  // outgoing byte holds for the whole interface cycle
  // link may take it anywhere in the cycle
  data_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // see [RULE3]
    !tick |=> $stable(data_o))
    else $error("bus byte changed between ticks");

  // transmit runs with dir low and the bus released
  // contention here would corrupt the link's bytes
  tx_dir_low_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // see [RULE1]
    (state_q == ST_TX) |-> (!dir_o && data_oe_o == '0))
    else $error("dir high during transmit");

  // bus driven only with dir high
  // drive without dir would fight the link's drivers
  drive_dir_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // see [RULE2]
    (data_oe_o != '0) |-> dir_o)
    else $error("bus driven with dir low");

  // a delivered usb byte is reported back to the core
  // core drops its offer on this pulse
  rx_taken_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // see [RULE11]
    rx_take |=> rx_taken_o)
    else $error("rx byte not reported taken");

  // turn-up lasts exactly one interface cycle
  // longer would waste bandwidth, shorter would skip the turnaround
  turn_up_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // see [RULE5]
    (state_q == ST_TURN_UP && tick) |=> (state_q == ST_DRIVE || state_q == ST_PARKED))
    else $error("turn-up not one cycle");

  // no nxt while the bus turns back to the link
  // link ignores the bus then and could misread nxt as throttle
  turn_nxt_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // see [RULE5]
    (state_q == ST_TURN_DN) |-> !nxt_o)
    else $error("nxt during turnaround");

  // wake is a single-cycle pulse
  // ticks are never adjacent, so a longer pulse means a stuck flag
  wake_pulse_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // see [RULE9]
    wake_o |=> !wake_o)
    else $error("wake pulse too long");
endmodule

//--- verif/ulpi_link_model.sv
// behavioural model of the link controller facing the block
`timescale 1ns/1ps
module ulpi_link_model
  import ulpi_hs_pkg::*;
(
  input  wire logic              ifc_clk_i, // interface clock from device
  input  wire logic              dir_i,     // bus direction
  input  wire logic              nxt_i,     // throttle / valid
  input  wire logic [DATA_W-1:0] bus_i,     // resolved bus level
  output logic                   stp_o,     // stop to device
  output logic [DATA_W-1:0]      data_o,    // link bus value
  output logic                   drv_o      // high while link drives
);
  logic              dir_p;    // dir one interface cycle back
  logic              dir_s;    // dir settled in the last interface cycle
  logic              nxt_s;    // nxt settled in the last interface cycle
  logic [DATA_W-1:0] bus_s;    // bus settled in the last interface cycle
  logic [DATA_W-1:0] rx_q[$];  // usb bytes seen
  logic [DATA_W-1:0] cmd_q[$]; // status and readback bytes seen
  initial begin
    stp_o  = 1'b0;
    data_o = TXCMD_NONE; // idle bus held low
    dir_p  = 1'b0;
    dir_s  = 1'b0;
    nxt_s  = 1'b0;
    bus_s  = TXCMD_NONE;
  end
  // let go at once so the turnaround cycle absorbs the swap
  assign drv_o = ~dir_i;
  // copy mid-cycle: the device launches its outputs on the rising edge itself
  always @(negedge ifc_clk_i) begin
    dir_s <= dir_i;
    nxt_s <= nxt_i;
    bus_s <= bus_i;
  end
  // collect bytes; first cycle after a dir change is junk
  always @(posedge ifc_clk_i) begin
    if (dir_s && dir_p && nxt_s) rx_q.push_back(bus_s);
    else if (dir_s && dir_p) cmd_q.push_back(bus_s);
    dir_p <= dir_s;
  end
  // command then three bytes, each advanced only on nxt
  task automatic send(input logic [DATA_W-1:0] cmd, input logic [3*DATA_W-1:0] pay);
    int i;
    i = 0;
    @(posedge ifc_clk_i);
    data_o <= cmd; // nonzero command opens transfer
    while (i < 4) begin
      @(posedge ifc_clk_i);
      if (nxt_s && !dir_s) begin // next byte in the cycle after nxt
        if (i < 3) data_o <= pay[(2-i)*DATA_W +: DATA_W];
        i++;
      end
    end
    data_o <= TXCMD_NONE;
    stp_o  <= 1'b1; // one-cycle stop after the last byte
    @(posedge ifc_clk_i);
    stp_o  <= 1'b0;
  endtask
  // stop level change on an interface edge
  task automatic set_stp(input logic v);
    @(posedge ifc_clk_i);
    stp_o <= v;
  endtask
endmodule

//--- verif/tb_ulpi_bus_handshake.sv
// self-checking bench for the ulpi bus handshake block
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("BAD %0t %h %h", $time, (a), (e)); end end
`define WAITF(c, n) begin int k; k = 0; while (!(c) && k < (n)) begin \
  @(posedge clk_sys_i); k++; end `CHK((c), 1'b1) end
module tb_ulpi_bus_handshake
  import ulpi_hs_pkg::*;
;
  logic              clk_sys_i, rst_i, rx_valid_i, rxcmd_req_i, rd_valid_i, tx_ready_i;
  logic              ifc_clk_o, dir_o, nxt_o, rx_taken_o, rxcmd_taken_o, rd_taken_o, dir_q;
  logic              tx_valid_o, tx_last_o, wake_o, stp, link_drv, last_seen;
  logic [1:0]        mode_i;
  logic [DATA_W-1:0] rx_data_i, rxcmd_i, rd_data_i, data_o, data_oe_o, tx_data_o;
  logic [DATA_W-1:0] bus_w, bus_hold, link_data;
  logic [DATA_W-1:0] tx_q[$]; // bytes captured from the link
  int                bad_count, n_checks;
  wire  [2:0]        taken = {rd_taken_o, rxcmd_taken_o, rx_taken_o};
  ulpi_bus_handshake u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ifc_clk_o(ifc_clk_o),
    .stp_i(stp), .data_i(bus_w), .data_o(data_o), .data_oe_o(data_oe_o), .dir_o(dir_o),
    .nxt_o(nxt_o), .mode_i(mode_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
    .rxcmd_req_i(rxcmd_req_i), .rxcmd_i(rxcmd_i), .rd_valid_i(rd_valid_i),
    .rd_data_i(rd_data_i), .rx_taken_o(rx_taken_o), .rxcmd_taken_o(rxcmd_taken_o),
    .rd_taken_o(rd_taken_o), .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .wake_o(wake_o));
  ulpi_link_model u_link (.ifc_clk_i(ifc_clk_o), .dir_i(dir_o), .nxt_i(nxt_o), .bus_i(bus_w),
    .stp_o(stp), .data_o(link_data), .drv_o(link_drv));
  // undriven bus toggles so a stale value never passes
  always_comb bus_w = |data_oe_o ? data_o : (link_drv ? link_data : ~bus_hold);
  always #2 clk_sys_i = ~clk_sys_i;
  // device may drive only once dir has been high for one sys clock
  always @(posedge clk_sys_i) begin
    bus_hold <= bus_w;
    if (!rst_i && dir_q === 1'b0) `CHK(data_oe_o, {DATA_W{1'b0}})
    dir_q <= dir_o;
    if (tx_valid_o === 1'b1) tx_q.push_back(tx_data_o);
    if (tx_last_o === 1'b1) last_seen <= 1'b1;
  end
  task automatic results();
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // offer one byte on a core channel, hold until taken
  task automatic offer(input int ch, input logic [DATA_W-1:0] b, input logic last);
    case (ch)
      0: begin rx_valid_i <= 1'b1; rx_data_i <= b; end
      1: begin rxcmd_req_i <= 1'b1; rxcmd_i <= b; end
      default: begin rd_valid_i <= 1'b1; rd_data_i <= b; end
    endcase
    do @(posedge clk_sys_i); while (taken[ch] !== 1'b1);
    if (last) {rx_valid_i, rxcmd_req_i, rd_valid_i} <= 3'h0;
  endtask
  function automatic logic seen(input logic [DATA_W-1:0] v);
    seen = 1'b0;
    foreach (u_link.cmd_q[i]) if (u_link.cmd_q[i] === v) seen = 1'b1;
  endfunction
  task automatic t_idle();
    longint t0;
    repeat (20) @(posedge clk_sys_i);
    `CHK({dir_o, nxt_o}, 2'h0)
    @(posedge ifc_clk_o);
    t0 = $time;
    @(posedge ifc_clk_o);
    `CHK($time - t0, 64'h20)
    @(posedge clk_sys_i);
  endtask
  task automatic t_rx();
    offer(0, 8'hA5, 1'b0);
    offer(0, 8'h3C, 1'b0);
    offer(0, 8'hFF, 1'b1);
    repeat (64) @(posedge clk_sys_i);
    `CHK(u_link.rx_q.size(), 3)
    `CHK({u_link.rx_q[0], u_link.rx_q[1], u_link.rx_q[2]}, 24'hA53CFF)
    `CHK(dir_o, 1'b0)
  endtask
  task automatic t_status();
    offer(1, 8'h5A, 1'b1);
    repeat (64) @(posedge clk_sys_i);
    offer(2, 8'hC3, 1'b1);
    repeat (64) @(posedge clk_sys_i);
    `CHK(seen(8'h5A), 1'b1)
    `CHK(seen(8'hC3), 1'b1)
    `CHK(u_link.rx_q.size(), 3)
  endtask
  // core stalls first: no nxt may appear until it is ready
  task automatic t_tx();
    fork
      u_link.send(8'h41, 24'h112233);
      begin
        repeat (48) begin @(posedge clk_sys_i); `CHK(nxt_o, 1'b0) end
        tx_ready_i <= 1'b1;
      end
    join
    repeat (32) @(posedge clk_sys_i);
    `CHK({tx_q[$-2], tx_q[$-1], tx_q[$]}, 24'h112233)
    `CHK(last_seen, 1'b1)
  endtask
  // stop in mid-delivery with the offer still standing
  task automatic t_abort();
    rx_valid_i <= 1'b1;
    rx_data_i  <= 8'h77;
    `WAITF(nxt_o && dir_o, 80)
    u_link.set_stp(1'b1);
    u_link.set_stp(1'b0);
    `WAITF(!dir_o, 48)
    rx_valid_i <= 1'b0;
    repeat (64) @(posedge clk_sys_i);
  endtask
  task automatic t_modes();
    for (int m = 1; m < 4; m++) begin
      mode_i <= 2'(m);
      `WAITF(dir_o, 40)
      repeat (64) begin @(posedge clk_sys_i); `CHK(dir_o, 1'b1) end
      u_link.set_stp(1'b1);
      `WAITF(wake_o, 64)
      mode_i <= MODE_SYNC;
      `WAITF(!dir_o, 64)
      u_link.set_stp(1'b0);
      repeat (32) @(posedge clk_sys_i);
    end
  endtask
  initial begin
    {clk_sys_i, rx_valid_i, rxcmd_req_i, rd_valid_i, tx_ready_i, last_seen} = 6'h00;
    {rx_data_i, rxcmd_i, rd_data_i, bus_hold} = 32'h0;
    rst_i = 1'b1;
    mode_i = MODE_SYNC;
    bad_count = 0;
    n_checks = 0;
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_idle();
    t_rx();
    t_status();
    t_tx();
    t_abort();
    t_modes();
    results();
  end
  // hang guard, well beyond the few thousand cycles needed
  initial begin
    #100000;
    bad_count++;
    results();
  end
endmodule
